// [epi_unit.sv]
// pin interrupt unit: one dedicated pin with sense control, six pin-change inputs
// assumes asynchronous pins, one 100 mhz clock, avalon-mm master with waitrequest
//
// What this block does
// - dedicated request needs global and own enable
// - sample pin first; pulses over one clock count
// - sense bits 1:0 select low/any/fall/rise
// - mask bit 6 enables dedicated pin request
// - pins trigger even when driven as outputs
// - mask bit 5 enables pin-change request
// - any enabled pin-change input change requests
// - reserved mask and flag bits read zero
// - flag bit 6 sets on dedicated trigger
// - flags clear on vector or written one
// - low-level mode holds dedicated flag cleared
// - flag bit 5 sets on pin change
// - pending, enabled flag requests core vector
// - select bits 5:0 enable inputs; 7:6 read zero
// - level detection needs no edge history; change detection compares with the previous sample
// - vectors 0x0001 dedicated, 0x0002 pin change
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`include "epi_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module epi_unit (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dedicated_irq_pin,
  input  wire logic [5:0]  pin_change_inputs,
  input  wire logic        vector_ack,
  output logic             core_irq_req,
  output logic      [15:0] core_vector,
  output logic             irq
);
  import epi_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // pins are read through the synchroniser whatever drives them
  logic       ded_meta;
  logic       ded_sync;
  logic       ded_prev;
  logic [5:0] pc_meta;
  logic [5:0] pc_sync;
  logic [5:0] pc_prev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ded_meta <= 1'b1;
      ded_sync <= 1'b1;
      ded_prev <= 1'b1;
      pc_meta  <= 6'h00;
      pc_sync  <= 6'h00;
      pc_prev  <= 6'h00;
    end else begin
      ded_meta <= dedicated_irq_pin;
      ded_sync <= ded_meta;
      ded_prev <= ded_sync;
      pc_meta  <= pin_change_inputs;
      pc_sync  <= pc_meta;
      pc_prev  <= pc_sync;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  sense_ctl;
  logic [7:0]  src_mask;
  logic [7:0]  pc_select;
  logic        global_ie;
  logic        ded_flag;
  logic        pc_flag;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  epi_bus_state_type bus_state;

  epi_sense_type sense_mode;
  assign sense_mode = epi_sense_type'(sense_ctl[1:0]);

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  wire ded_rise  = ded_sync & ~ded_prev;
  wire ded_fall  = ~ded_sync & ded_prev;
  // low level is judged on the current sample alone, no history needed
  wire ded_low   = ~ded_sync;
  wire ded_trig  = (sense_mode == EPI_SENSE_ANY)  ? (ded_rise | ded_fall) :
                   (sense_mode == EPI_SENSE_FALL) ? ded_fall :
                   (sense_mode == EPI_SENSE_RISE) ? ded_rise : 1'b0;
  wire level_md  = (sense_mode == EPI_SENSE_LOW);
  wire pc_trig   = |((pc_sync ^ pc_prev) & pc_select[5:0]);

  // level mode raises the request straight from the pin, the flag stays 0
  wire ded_pend  = level_md ? ded_low : ded_flag;
  wire ded_req   = ded_pend & src_mask[`EPI_BIT_DED] & global_ie;
  wire pc_req    = pc_flag & src_mask[`EPI_BIT_PC] & global_ie;
  wire any_req   = ded_req | pc_req;
  // the dedicated pin has the lower vector and wins when both pend
  wire [15:0] next_vector = ded_req ? `EPI_VEC_DED :
                            pc_req  ? `EPI_VEC_PC  : `EPI_VEC_NONE;
  wire ack_ded   = vector_ack & core_irq_req & (core_vector == `EPI_VEC_DED);
  wire ack_pc    = vector_ack & core_irq_req & (core_vector == `EPI_VEC_PC);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        bus_req  = (avs_read | avs_write) & (bus_state == EPI_BUS_IDLE);
  wire        wr_go    = avs_write & (bus_state == EPI_BUS_IDLE);
  wire        rd_go    = avs_read & (bus_state == EPI_BUS_IDLE);
  wire        wr_lo    = wr_go & avs_byteenable[0];
  wire [7:0]  wbyte    = avs_writedata[7:0];
  wire        wr_sense = wr_lo & (avs_address == 5'(`EPI_ADDR_SENSE));
  wire        wr_smask = wr_lo & (avs_address == 5'(`EPI_ADDR_SRC_MASK));
  wire        wr_pend  = wr_lo & (avs_address == 5'(`EPI_ADDR_PEND));
  wire        wr_pcsel = wr_lo & (avs_address == 5'(`EPI_ADDR_PC_SEL));
  wire        wr_core  = wr_lo & (avs_address == `EPI_ADDR_CORE);
  wire        wr_imask = wr_lo & (avs_address == `EPI_ADDR_IRQ_MASK);
  wire        rd_istat = rd_go & (avs_address == `EPI_ADDR_IRQ_STAT);
  wire [7:0]  pend_rd  = {1'b0, ded_flag, pc_flag, 5'h00};
  wire [7:0]  rd_byte  =
    (avs_address == 5'(`EPI_ADDR_SENSE))    ? sense_ctl :
    (avs_address == 5'(`EPI_ADDR_SRC_MASK)) ? (src_mask & `EPI_SRC_MASK_USED) :
    (avs_address == 5'(`EPI_ADDR_PEND))     ? pend_rd :
    (avs_address == 5'(`EPI_ADDR_PC_SEL))   ? (pc_select & `EPI_PC_SEL_USED) :
    (avs_address == `EPI_ADDR_CORE)         ? {7'h00, global_ie} :
    (avs_address == `EPI_ADDR_VEC)          ? core_vector[7:0] :
    (avs_address == `EPI_ADDR_IRQ_STAT)     ? {6'h00, irq_stat} :
    (avs_address == `EPI_ADDR_IRQ_MASK)     ? {6'h00, irq_mask} : 8'h00;

  // ----------------------------------------------------------------
  // flags: set wins over any clear in the same cycle
  // ----------------------------------------------------------------
  wire next_ded_flag = ded_trig | (~level_md & ded_flag & ~ack_ded
                       & ~(wr_pend & wbyte[`EPI_BIT_DED]));
  wire next_pc_flag  = pc_trig | (pc_flag & ~ack_pc
                       & ~(wr_pend & wbyte[`EPI_BIT_PC]));
  // level mode logs only the onset of low, not every cycle it stays low
  wire [1:0] events  = {ded_trig | (level_md & ded_low & ded_prev), pc_trig};
  wire [1:0] next_irq_stat = events | (irq_stat & ~{2{rd_istat}});

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sense_ctl <= `EPI_RESET_BYTE;
      src_mask  <= `EPI_RESET_BYTE;
      pc_select <= `EPI_RESET_BYTE;
      global_ie <= 1'b0;
      irq_mask  <= 2'b00;
    end else begin
      if (wr_sense) sense_ctl <= wbyte;
      if (wr_smask) src_mask  <= wbyte & `EPI_SRC_MASK_USED;
      if (wr_pcsel) pc_select <= wbyte & `EPI_PC_SEL_USED;
      if (wr_core)  global_ie <= wbyte[0];
      if (wr_imask) irq_mask  <= wbyte[1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ded_flag <= 1'b0;
      pc_flag  <= 1'b0;
      irq_stat <= 2'b00;
    end else begin
      ded_flag <= next_ded_flag;
      pc_flag  <= next_pc_flag;
      irq_stat <= next_irq_stat;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // vectoring is shown to the core one cycle after the flag sets
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_irq_req    <= 1'b0;
      core_vector     <= `EPI_VEC_NONE;
      irq             <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      bus_state       <= EPI_BUS_IDLE;
    end else begin
      core_irq_req <= any_req & ~(vector_ack & core_irq_req);
      core_vector  <= next_vector;
      irq          <= |(next_irq_stat & irq_mask);
      if (bus_req) begin
        avs_readdata    <= {24'h00_0000, rd_byte};
        avs_waitrequest <= 1'b0;
        bus_state       <= EPI_BUS_DONE;
      end else begin
        avs_waitrequest <= 1'b1;
        bus_state       <= EPI_BUS_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fall_seen;
    ded_prev && !ded_sync && sense_mode == EPI_SENSE_FALL;
  endsequence

  property p_fall_sets;
    @(posedge sys_clk) disable iff (rst) s_fall_seen |=> ded_flag;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge missed");

  property p_level_clear;
    @(posedge sys_clk) disable iff (rst) level_md |=> (level_md -> !ded_flag);
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("flag set in level mode");

  property p_pc_sets;
    @(posedge sys_clk) disable iff (rst) pc_trig |=> pc_flag;
  endproperty
  a_pc_sets: assert property (p_pc_sets) else $error("pin change missed");

  property p_pipe;
    @(posedge sys_clk) disable iff (rst)
      $rose(pc_meta[0]) && pc_select[0] && $stable(pc_select) |=> ##1 pc_flag;
  endproperty
  a_pipe: assert property (p_pipe) else $error("sync path too slow");

  property p_gate;
    @(posedge sys_clk) disable iff (rst) !global_ie |=> !core_irq_req;
  endproperty
  a_gate: assert property (p_gate) else $error("request without global enable");

  property p_ded_vec;
    @(posedge sys_clk) disable iff (rst)
      ded_flag && !level_md && src_mask[6] && global_ie |=> core_vector == 16'h0001;
  endproperty
  a_ded_vec: assert property (p_ded_vec) else $error("wrong dedicated vector");

  property p_pc_mask;
    @(posedge sys_clk) disable iff (rst)
      pc_flag && !src_mask[5] && !ded_req |=> !core_irq_req;
  endproperty
  a_pc_mask: assert property (p_pc_mask) else $error("pin change not masked");

  property p_w1c;
    @(posedge sys_clk) disable iff (rst)
      wr_pend && wbyte[5] && !pc_trig && !$past(pc_trig) |=> !pc_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one left flag");

  property p_resv;
    @(posedge sys_clk) disable iff (rst)
      rd_go && avs_address == 5'h8 |=> avs_readdata[7] == 1'b0 && avs_readdata[4:0] == 5'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
endmodule : epi_unit
`default_nettype wire

// [epi_consts.svh]
// offsets, field positions, reset values and vector addresses of the pin interrupt unit
// assumes a 32-bit avalon-mm slave with word addresses in bytes
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH
`define EPI_ADDR_SENSE      4'h0
`define EPI_ADDR_SRC_MASK   4'h4
`define EPI_ADDR_PEND       4'h8
`define EPI_ADDR_PC_SEL     4'hc
`define EPI_ADDR_CORE       5'h10
`define EPI_ADDR_VEC        5'h14
`define EPI_ADDR_IRQ_STAT   5'h18
`define EPI_ADDR_IRQ_MASK   5'h1c
`define EPI_BIT_DED         6
`define EPI_BIT_PC          5
`define EPI_SRC_MASK_USED   8'h60
`define EPI_PC_SEL_USED     8'h3f
`define EPI_RESET_BYTE      8'h00
`define EPI_VEC_DED         16'h0001
`define EPI_VEC_PC          16'h0002
`define EPI_VEC_NONE        16'h0000
`endif

// [epi_pkg.sv]
// types of the pin interrupt unit
// assumes epi_consts.svh is on the include path
package epi_pkg;
  typedef enum logic [1:0] {
    EPI_SENSE_LOW  = 2'b00,
    EPI_SENSE_ANY  = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_type;
  typedef enum logic [1:0] {
    EPI_BUS_IDLE = 2'b00,
    EPI_BUS_DONE = 2'b01
  } epi_bus_state_type;
endpackage : epi_pkg

// [epi_core_model.sv]
// core-side partner: acknowledges vector requests, records the vector taken
// assumes the unit's core_irq_req and core_vector outputs on sys_clk
`timescale 1ns/10ps
`default_nettype none
module epi_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ack_enable,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        core_irq_req,
  input  wire logic [15:0] core_vector,
  output logic             vector_ack,
  output logic      [15:0] taken_vector
);
  logic [3:0] wait_cnt;
  // a slow core lets the request stand ack_wait cycles before it vectors
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vector_ack   <= 1'b0;
      wait_cnt     <= 4'h0;
      taken_vector <= 16'h0000;
    end else begin
      vector_ack <= ack_enable && core_irq_req && !vector_ack && (wait_cnt >= ack_wait);
      wait_cnt   <= (core_irq_req && !vector_ack) ? wait_cnt + 4'h1 : 4'h0;
      if (vector_ack && core_irq_req) begin
        taken_vector <= core_vector;
      end
    end
  end
endmodule : epi_core_model
`default_nettype wire

// [test_external_pin_interrupt_unit.sv]
// self-checking bench of the pin interrupt unit
// assumes epi_consts.svh on the include path and the core-side partner model
`include "epi_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_external_pin_interrupt_unit;
  logic        sys_clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_be;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ded_pin;
  logic [5:0]  pc_in;
  logic        vector_ack;
  logic        core_irq_req;
  logic [15:0] core_vector;
  logic        irq;
  logic        ack_enable;
  logic [3:0]  ack_wait;
  logic [15:0] taken_vector;
  int          n_errors;
  int          check_count;
  epi_unit u_epi_unit (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dedicated_irq_pin(ded_pin), .pin_change_inputs(pc_in), .vector_ack(vector_ack),
    .core_irq_req(core_irq_req), .core_vector(core_vector), .irq(irq));
  epi_core_model u_epi_core_model (.sys_clk(sys_clk), .rst(rst), .ack_enable(ack_enable),
    .ack_wait(ack_wait), .core_irq_req(core_irq_req), .core_vector(core_vector),
    .vector_ack(vector_ack), .taken_vector(taken_vector));
  always #5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // the request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rd_n, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_read      <= rd_n;
    avs_write     <= !rd_n;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) n_errors++;
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    bus(1'b1, a, 8'h00, q);
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask : settle
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] q;
    rd(`EPI_ADDR_PEND, q);
    `CHK("pending reset", 8'h00, q)
    wr(`EPI_ADDR_SRC_MASK, 8'hff);
    rd(`EPI_ADDR_SRC_MASK, q);
    `CHK("source mask", 8'h60, q)
    avs_be <= 4'h0;
    wr(`EPI_ADDR_SRC_MASK, 8'h00);
    avs_be <= 4'hf;
    rd(`EPI_ADDR_SRC_MASK, q);
    `CHK("lane off write", 8'h60, q)
    wr(`EPI_ADDR_PC_SEL, 8'hff);
    rd(`EPI_ADDR_PC_SEL, q);
    `CHK("pin select", 8'h3f, q)
    rd(5'h02, q);
    `CHK("unmapped", 8'h00, q)
    wr(`EPI_ADDR_SRC_MASK, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_edge();
    logic [7:0] q;
    wr(`EPI_ADDR_CORE, 8'h01);
    for (int m = 1; m < 4; m++) begin
      wr(`EPI_ADDR_SENSE, 8'(m));
      wr(`EPI_ADDR_PEND, 8'h40);
      @(posedge sys_clk);
      ded_pin <= 1'b0;
      settle();
      rd(`EPI_ADDR_PEND, q);
      `CHK("fall flag", (m != 3) ? 8'h40 : 8'h00, q)
      wr(`EPI_ADDR_PEND, 8'h40);
      @(posedge sys_clk);
      ded_pin <= 1'b1;
      settle();
      rd(`EPI_ADDR_PEND, q);
      `CHK("rise flag", (m != 2) ? 8'h40 : 8'h00, q)
    end
    `CHK("masked request", 1'b0, core_irq_req)
    wr(`EPI_ADDR_SRC_MASK, 8'h40);
    settle();
    `CHK("request", 1'b1, core_irq_req)
    `CHK("vector", `EPI_VEC_DED, core_vector)
    wr(`EPI_ADDR_PEND, 8'h00);
    rd(`EPI_ADDR_PEND, q);
    `CHK("write zero keeps", 8'h40, q)
    wr(`EPI_ADDR_CORE, 8'h00);
    settle();
    `CHK("global off", 1'b0, core_irq_req)
    wr(`EPI_ADDR_PEND, 8'h40);
    rd(`EPI_ADDR_PEND, q);
    `CHK("write one clears", 8'h00, q)
    @(posedge sys_clk);
    ded_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ded_pin <= 1'b1;
    settle();
    rd(`EPI_ADDR_PEND, q);
    `CHK("short pulse", 8'h40, q)
    wr(`EPI_ADDR_PEND, 8'h40);
    $display("test edge done");
  endtask : t_edge
  task automatic t_level();
    logic [7:0] q;
    wr(`EPI_ADDR_CORE, 8'h01);
    wr(`EPI_ADDR_SENSE, 8'h00);
    @(posedge sys_clk);
    ded_pin <= 1'b0;
    settle();
    `CHK("level request", 1'b1, core_irq_req)
    rd(`EPI_ADDR_PEND, q);
    `CHK("level flag", 8'h00, q)
    @(posedge sys_clk);
    ded_pin <= 1'b1;
    settle();
    `CHK("level gone", 1'b0, core_irq_req)
    wr(`EPI_ADDR_SRC_MASK, 8'h00);
    wr(`EPI_ADDR_SENSE, 8'h03);
    $display("test level done");
  endtask : t_level
  task automatic t_pc();
    logic [7:0] q;
    rd(`EPI_ADDR_IRQ_STAT, q);
    ack_enable <= 1'b1;
    ack_wait   <= 4'h3;
    wr(`EPI_ADDR_PC_SEL, 8'h01);
    wr(`EPI_ADDR_IRQ_MASK, 8'h01);
    wr(`EPI_ADDR_SRC_MASK, 8'h20);
    pc_in <= 6'h02;
    settle();
    `CHK("unselected input", 1'b0, core_irq_req)
    pc_in <= 6'h03;
    repeat (14) @(posedge sys_clk);
    `CHK("pc vector", `EPI_VEC_PC, taken_vector)
    `CHK("irq line", 1'b1, irq)
    rd(`EPI_ADDR_PEND, q);
    `CHK("cleared by vector", 8'h00, q)
    rd(`EPI_ADDR_IRQ_STAT, q);
    `CHK("status", 8'h01, q)
    settle();
    `CHK("irq after read", 1'b0, irq)
    wr(`EPI_ADDR_IRQ_MASK, 8'h00);
    wr(`EPI_ADDR_SRC_MASK, 8'h00);
    ack_enable <= 1'b0;
    pc_in <= 6'h02;
    settle();
    `CHK("irq masked", 1'b0, irq)
    `CHK("pc disabled", 1'b0, core_irq_req)
    rd(`EPI_ADDR_PEND, q);
    `CHK("pc flag", 8'h20, q)
    $display("test pin change done");
  endtask : t_pc
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_be = 4'hf;
    ded_pin = 1'b1;
    pc_in = 6'h00;
    ack_enable = 1'b0;
    ack_wait = 4'h0;
    n_errors = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_edge();
    t_level();
    t_pc();
    finish_test();
  end
  // the tests need well under a thousand cycles; this bound only cuts a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule : test_external_pin_interrupt_unit
`default_nettype wire
